// >>> verilog/test_point_strap_debug_port.sv
// test-point strap capture and debug output port
// assumes the pins arrive asynchronously and the reset pin is async too;
// pad pull-downs and the tri-state wire are resolved outside this module
`include "test_point_consts.svh"

// Functional notes
// - pins are inputs while reset pin is low, outputs after release under clock debug capture
// - pin levels captured at reset release, held until the next release
// - capture only on rising reset pin or on sys_rst release with the pin high; later strap changes ignored
// - every pin has a weak pull-down, so open pins capture zero
// - all-zero capture keeps all eight pins high-impedance
// - clock debug capture drives 60, 30, variable and 7.5 MHz clocks
// - clock debug capture drives pins 3, 5, 6 high and pin 4 low
// - captured pins 3 to 6 select a device mode option
// - software may reroute any pin's source at any time after release
module test_point_strap_debug_port (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic system_reset_n_in,
    input wire logic [7:0] test_point_pins_in,
    output logic [7:0] test_point_pins_out,
    output logic [7:0] test_point_pins_oe,
    output logic [7:0] test_point_pull_down_en,
    output logic [3:0] mode_option,
    output logic port_running,
    input wire logic sw_route_wr,
    input wire logic [2:0] sw_route_pin,
    input wire test_point_pkg::tp_src_e sw_route_src,
    input wire test_point_pkg::nco_step_t var_clk_step
);
    import test_point_pkg::*;

    // ============================================================
    // declarations
    logic rst_pin_s1_reg;
    logic rst_pin_s2_reg;
    logic rst_pin_s3_reg;
    logic [7:0] pins_s1_reg;
    logic [7:0] pins_s2_reg;
    port_state_e state_reg;
    port_state_e state_next;
    logic [7:0] capture_reg;
    logic [7:0] capture_next;
    tp_src_e route_reg [8];
    tp_src_e route_next [8];
    tp_src_e default_route [8];
    logic [7:0] out_reg;
    logic [7:0] out_next;
    logic [7:0] oe_reg;
    logic [7:0] oe_next;
    logic release_pulse;
    logic cap_debug;
    logic sw_take;
    nco_step_t var_step_clamped;
    nco_step_t nco_steps [4];
    logic [3:0] nco_clks;

    // ============================================================
    // synchronisers: the reset pin and straps come from the board
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rst_pin_s1_reg <= 1'b0;
            rst_pin_s2_reg <= 1'b0;
            rst_pin_s3_reg <= 1'b0;
            pins_s1_reg <= `TP_ALL_OFF;
            pins_s2_reg <= `TP_ALL_OFF;
        end else begin
            rst_pin_s1_reg <= system_reset_n_in;
            rst_pin_s2_reg <= rst_pin_s1_reg;
            rst_pin_s3_reg <= rst_pin_s2_reg;
            pins_s1_reg <= test_point_pins_in;
            pins_s2_reg <= pins_s1_reg;
        end
    end

    // ============================================================
    // release detection; straps and reset share equal sync depth, so the
    // sampled straps are the levels seen as the reset pin went high
    assign release_pulse = rst_pin_s2_reg & ~rst_pin_s3_reg;
    assign state_next = !rst_pin_s2_reg ? PORT_STRAP :
        (release_pulse ? PORT_RUN : state_reg);
    assign capture_next = release_pulse ? pins_s2_reg : capture_reg;
    assign cap_debug = capture_next[`TP_SEL_MSB:`TP_SEL_LSB] == `TP_CAP_CLK_DEBUG;
    // software writes only count once the port is running and the reset pin is high
    assign sw_take = sw_route_wr && (state_reg == PORT_RUN) && rst_pin_s2_reg;

    // ============================================================
    // default routing per capture value; unknown values stay quiet
    assign default_route[0] = cap_debug ? SRC_CLK_A : SRC_HIZ;
    assign default_route[1] = cap_debug ? SRC_CLK_B : SRC_HIZ;
    assign default_route[2] = cap_debug ? SRC_CLK_VAR : SRC_HIZ;
    assign default_route[3] = cap_debug ? SRC_HIGH : SRC_HIZ;
    assign default_route[4] = cap_debug ? SRC_LOW : SRC_HIZ;
    assign default_route[5] = cap_debug ? SRC_HIGH : SRC_HIZ;
    assign default_route[6] = cap_debug ? SRC_HIGH : SRC_HIZ;
    assign default_route[7] = cap_debug ? SRC_CLK_D : SRC_HIZ;

    // ============================================================
    // variable clock, held inside its documented range
    assign var_step_clamped = (var_clk_step < `TP_STEP_VAR_MIN) ? `TP_STEP_VAR_MIN :
        ((var_clk_step > `TP_STEP_VAR_MAX) ? `TP_STEP_VAR_MAX : var_clk_step);
    assign nco_steps[0] = `TP_STEP_A;
    assign nco_steps[1] = `TP_STEP_B;
    assign nco_steps[2] = var_step_clamped;
    assign nco_steps[3] = `TP_STEP_D;

    // ============================================================
    // per-pin routing and output selection
    generate
        for (genvar i = 0; i < `TP_PIN_COUNT; i++) begin : g_pin
            assign route_next[i] = !rst_pin_s2_reg ? SRC_HIZ :
                (release_pulse ? default_route[i] :
                ((sw_take && sw_route_pin == 3'(i)) ? sw_route_src : route_reg[i]));
            assign oe_next[i] = (route_reg[i] != SRC_HIZ) && rst_pin_s2_reg;
            assign out_next[i] = (route_reg[i] == SRC_HIGH) ||
                (route_reg[i] == SRC_CLK_A && nco_clks[0]) ||
                (route_reg[i] == SRC_CLK_B && nco_clks[1]) ||
                (route_reg[i] == SRC_CLK_VAR && nco_clks[2]) ||
                (route_reg[i] == SRC_CLK_D && nco_clks[3]);
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    route_reg[i] <= SRC_HIZ;
                end else begin
                    route_reg[i] <= route_next[i];
                end
            end
        end
        for (genvar k = 0; k < 4; k++) begin : g_nco
            nco_clock u_nco (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .step(nco_steps[k]),
                .clk_out(nco_clks[k])
            );
        end
    endgenerate

    // ============================================================
    // state, capture and registered pad drive
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= PORT_STRAP;
            capture_reg <= `TP_ALL_OFF;
            out_reg <= `TP_ALL_OFF;
            oe_reg <= `TP_ALL_OFF;
        end else begin
            state_reg <= state_next;
            capture_reg <= capture_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign test_point_pins_out = out_reg;
    assign test_point_pins_oe = oe_reg;
    // pads keep a weak pull-down always on, so open straps read zero
    assign test_point_pull_down_en = `TP_ALL_ON;
    assign mode_option = capture_reg[`TP_MODE_MSB:`TP_MODE_LSB];
    assign port_running = (state_reg == PORT_RUN);

    // ============================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_release_with(logic [2:0] pat);
        release_pulse && pins_s2_reg[`TP_SEL_MSB:`TP_SEL_LSB] == pat;
    endsequence

    sequence s_quiet_run;
        rst_pin_s2_reg && !sw_route_wr;
    endsequence

    AST_INPUTS_IN_RESET: assert property (!rst_pin_s2_reg |=> test_point_pins_oe == 8'h00)
        else $error("pins driven while reset pin low");
    AST_OUTPUTS_AFTER_RELEASE: assert property (
        s_release_with(`TP_CAP_CLK_DEBUG) ##1 rst_pin_s2_reg |=> test_point_pins_oe == 8'hff)
        else $error("clock debug pins not driven after release");
    AST_CAPTURE_VALUE: assert property (
        release_pulse |=> capture_reg == $past(pins_s2_reg) &&
        mode_option == $past(pins_s2_reg[6:3]))
        else $error("strap capture mismatch");
    AST_CAPTURE_HOLDS: assert property (
        state_reg == PORT_RUN && !release_pulse |=> $stable(capture_reg))
        else $error("capture changed without reset release");
    AST_DEFAULT_QUIET: assert property (
        s_release_with(`TP_CAP_DEFAULT) ##1 s_quiet_run |=> test_point_pins_oe == 8'h00)
        else $error("default capture drives a pin");
    // the fast clock never holds one level for four samples; looking back keeps a
    // later software reroute from tripping the check
    AST_CLK_A_RUNS: assert property (
        (route_reg[0] == SRC_CLK_A && state_reg == PORT_RUN)[*5]
        |-> !(test_point_pins_out[0] == $past(test_point_pins_out[0]) &&
        $past(test_point_pins_out[0]) == $past(test_point_pins_out[0], 2) &&
        $past(test_point_pins_out[0], 2) == $past(test_point_pins_out[0], 3)))
        else $error("fast debug clock stuck");
    AST_STATIC_LEVELS: assert property (
        s_release_with(`TP_CAP_CLK_DEBUG) ##1 s_quiet_run
        |=> test_point_pins_out[6:3] == 4'hd)
        else $error("static debug levels wrong");
    // first run cycle is skipped: the capture has just been loaded there
    AST_MODE_FROM_STRAP: assert property (
        state_reg == PORT_RUN && $past(state_reg) == PORT_RUN
        |-> mode_option == capture_reg[6:3] && capture_reg == $past(capture_reg))
        else $error("mode option drifted");
    AST_SW_REROUTE: assert property (
        sw_take |=> route_reg[$past(sw_route_pin)] == $past(sw_route_src))
        else $error("software route not applied");
    AST_OTHER_QUIET: assert property (
        release_pulse && pins_s2_reg[2:0] != 3'h0 && pins_s2_reg[2:0] != 3'h2
        ##1 s_quiet_run |=> test_point_pins_oe == 8'h00)
        else $error("unknown capture drives a pin");
endmodule

// >>> inc/test_point_consts.svh
// test-point port constants: capture patterns, pin numbers, clock figures
// assumes inclusion by bare name from design files of the test-point port
`ifndef TEST_POINT_CONSTS_SVH
`define TEST_POINT_CONSTS_SVH

// ============================================================
// pin group
`define TP_PIN_COUNT 8
`define TP_PIN_IDX_W 3
`define TP_ALL_ON 8'hff
`define TP_ALL_OFF 8'h00
`define TP_MODE_LSB 3
`define TP_MODE_MSB 6

// ============================================================
// capture patterns on pins 2..0 (pin 3 and up are don't care here)
`define TP_SEL_LSB 0
`define TP_SEL_MSB 2
`define TP_CAP_DEFAULT 3'h0
`define TP_CAP_CLK_DEBUG 3'h2

// ============================================================
// debug clock figures in kHz and the reference clock rate
`define TP_REF_KHZ 64'd250000
`define TP_CLK_A_KHZ 64'd60000
`define TP_CLK_B_KHZ 64'd30000
`define TP_CLK_D_KHZ 64'd7500
`define TP_VAR_MIN_KHZ 64'd700
`define TP_VAR_MAX_KHZ 64'd22500

// oscillator accumulator: output frequency = step * ref / 2^width
`define TP_NCO_W 16
`define TP_NCO_SPAN 64'd65536
`define TP_STEP(khz) (((khz) * `TP_NCO_SPAN + `TP_REF_KHZ - 64'd1) / `TP_REF_KHZ)
`define TP_STEP_A 16'(`TP_STEP(`TP_CLK_A_KHZ))
`define TP_STEP_B 16'(`TP_STEP(`TP_CLK_B_KHZ))
`define TP_STEP_D 16'(`TP_STEP(`TP_CLK_D_KHZ))
`define TP_STEP_VAR_MIN 16'(`TP_STEP(`TP_VAR_MIN_KHZ))
`define TP_STEP_VAR_MAX 16'(((`TP_VAR_MAX_KHZ) * `TP_NCO_SPAN) / `TP_REF_KHZ)
`define TP_NCO_RST 16'h0000

`endif

// >>> inc/test_point_pkg.sv
// types shared by the test-point port and its clock generators
// assumes nothing beyond a SystemVerilog compiler
package test_point_pkg;

    // ============================================================
    // port state: strap inputs while reset pin low, routed pins drive after release
    typedef enum logic [1:0] {
        PORT_STRAP = 2'b01,
        PORT_RUN = 2'b10
    } port_state_e;

    // ============================================================
    // what drives one test-point pin
    typedef enum logic [2:0] {
        SRC_HIZ = 3'h0,
        SRC_LOW = 3'h1,
        SRC_HIGH = 3'h2,
        SRC_CLK_A = 3'h3,
        SRC_CLK_B = 3'h4,
        SRC_CLK_VAR = 3'h5,
        SRC_CLK_D = 3'h6
    } tp_src_e;

    typedef logic [15:0] nco_step_t;

endpackage

// >>> verilog/nco_clock.sv
// phase accumulator clock source for the debug outputs
// assumes a free-running reference clock and a synchronous reset
`include "test_point_consts.svh"

module nco_clock (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire test_point_pkg::nco_step_t step,
    output logic clk_out
);
    import test_point_pkg::*;

    logic [15:0] phase_reg;
    logic [15:0] phase_next;
    logic clk_out_reg;

    // ============================================================
    // accumulator; average frequency is step * ref / 2^16, edges jitter by one cycle
    assign phase_next = phase_reg + step;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_reg <= `TP_NCO_RST;
            clk_out_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            clk_out_reg <= phase_next[`TP_NCO_W-1];
        end
    end

    assign clk_out = clk_out_reg;
endmodule

// >>> test/strap_board_model.sv
// board side of the test-point port: strap pull-ups, pad resolution, power monitor
// assumes pull-down and output enables of the port are active high
module strap_board_model (
    input wire logic [7:0] strap_pull_up,
    input wire logic supplies_ok,
    input wire logic [7:0] pins_out,
    input wire logic [7:0] pins_oe,
    input wire logic [7:0] pull_down_en,
    output logic [7:0] pins_wire,
    output logic system_reset_n_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // pad level: port drive wins, then a fitted pull-up, then the weak pull-down;
    // a pad with nothing on it shows the inverse of pins_out, never a guess
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pins_oe[i]) begin
                pins_wire[i] = pins_out[i];
            end else if (strap_pull_up[i]) begin
                pins_wire[i] = 1'b1;
            end else begin
                pins_wire[i] = pull_down_en[i] ? 1'b0 : ~pins_out[i];
            end
        end
    end

    // ============================================================
    // monitor holds the reset pin low until supplies are good
    assign system_reset_n_in = supplies_ok;
endmodule

// >>> test/tb_top.sv
// self-checking bench for the test-point strap and debug port
// assumes the board model resolves pads and drives the reset pin
`include "test_point_consts.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import test_point_pkg::*;

    typedef struct {logic [7:0] strap; logic [7:0] oe; logic [3:0] mode;} row_s;
    row_s rows[6] = '{'{8'h00, 8'h00, 4'h0}, '{8'h0b, 8'h00, 4'h1}, '{8'h05, 8'h00, 4'h0},
        '{8'h8a, 8'hff, 4'h1}, '{8'h02, 8'hff, 4'h0}, '{8'h7a, 8'hff, 4'hf}};
    logic ref_clk = 1'b0;
    logic sys_rst, supplies_ok, rst_n, port_running, sw_route_wr;
    logic [7:0] strap, pins_wire, pins_out, pins_oe, pd_en;
    logic [3:0] mode_option;
    logic [2:0] sw_route_pin;
    tp_src_e sw_route_src;
    nco_step_t var_clk_step;
    int n_errors = 0;
    int n_compared = 0;
    int rises[8];

    always #2 ref_clk = ~ref_clk;

    strap_board_model board (.strap_pull_up(strap), .supplies_ok(supplies_ok),
        .pins_out(pins_out), .pins_oe(pins_oe), .pull_down_en(pd_en),
        .pins_wire(pins_wire), .system_reset_n_in(rst_n));

    test_point_strap_debug_port uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .system_reset_n_in(rst_n), .test_point_pins_in(pins_wire),
        .test_point_pins_out(pins_out), .test_point_pins_oe(pins_oe),
        .test_point_pull_down_en(pd_en), .mode_option(mode_option),
        .port_running(port_running), .sw_route_wr(sw_route_wr), .sw_route_pin(sw_route_pin),
        .sw_route_src(sw_route_src), .var_clk_step(var_clk_step));

    // ============================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // straps change only while the pin is low, so they are stable around the rise
    task automatic cycle_reset_pin(input logic [7:0] s);
        supplies_ok = 1'b0;
        strap = s;
        repeat (6) @(negedge ref_clk);
        check(pins_oe, 8'h00);
        supplies_ok = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask

    task automatic route(input logic [2:0] p, input tp_src_e s);
        sw_route_pin = p;
        sw_route_src = s;
        sw_route_wr = 1'b1;
        @(negedge ref_clk);
        sw_route_wr = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask

    // rising edges over 1000 cycles, i.e. 4 us of pad activity
    task automatic count_rises();
        logic [7:0] prev;
        rises = '{default: 0};
        prev = pins_wire;
        repeat (1000) begin
            @(negedge ref_clk);
            for (int k = 0; k < 8; k++) rises[k] += int'(pins_wire[k] && !prev[k]);
            prev = pins_wire;
        end
    endtask

    // edges jitter by a reference cycle, so allow a little slack
    function automatic logic near(input int n, input int e);
        return (n >= e - 2) && (n <= e + 2);
    endfunction

    // ============================================================
    // hang guard: the whole run needs well under 3000 cycles
    initial begin
        #40000;
        n_errors++;
        end_sim();
    end

    // ============================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        supplies_ok = 1'b0;
        strap = 8'h00;
        sw_route_wr = 1'b0;
        sw_route_pin = 3'h0;
        sw_route_src = SRC_HIZ;
        var_clk_step = 16'h1000;
        repeat (6) @(negedge ref_clk);
        check(pd_en, 8'hff);
        check(port_running, 1'b0);
        sys_rst = 1'b0;
        route(3'h5, SRC_HIGH); // refused while the port is not running
        foreach (rows[i]) begin
            cycle_reset_pin(rows[i].strap);
            check(port_running, 1'b1);
            check(mode_option, rows[i].mode);
            check(pins_oe, rows[i].oe);
            if (rows[i].oe == 8'hff) check(pins_out[6:3], 4'b1101);
        end
        // last row left the clock debug pattern running
        count_rises();
        check(near(rises[0], int'(`TP_CLK_A_KHZ * 4 / 1000)), 1'b1);
        check(near(rises[1], int'(`TP_CLK_B_KHZ * 4 / 1000)), 1'b1);
        check(near(rises[2], 62), 1'b1);
        check(near(rises[7], int'(`TP_CLK_D_KHZ * 4 / 1000)), 1'b1);
        // strap moves after release must not disturb the capture
        strap = 8'h00;
        repeat (10) @(negedge ref_clk);
        check(mode_option, 4'hf);
        check(pins_oe, 8'hff);
        route(3'h0, SRC_HIZ);
        check(pins_oe, 8'hfe);
        route(3'h4, SRC_HIGH);
        check(pins_out[4], 1'b1);
        cycle_reset_pin(8'h00);
        check(mode_option, 4'h0);
        check(pins_oe, 8'h00);
        // pads are undriven now, so a late strap really reaches the synchronisers
        strap = 8'h7a;
        repeat (10) @(negedge ref_clk);
        check(mode_option, 4'h0);
        check(pins_oe, 8'h00);
        strap = 8'h00;
        repeat (4) @(negedge ref_clk);
        // second system reset in mid-run
        sys_rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check(pins_oe, 8'h00);
        check(port_running, 1'b0);
        sys_rst = 1'b0;
        @(negedge ref_clk);
        check(port_running, 1'b0);
        check(pins_oe, 8'h00);
        @(negedge ref_clk);
        check(pins_oe, 8'h00);
        check(mode_option, 4'h0);
        // pin already high: the synchroniser restarts low, so a capture follows
        repeat (6) @(negedge ref_clk);
        check(port_running, 1'b1);
        check(pins_oe, 8'h00);
        end_sim();
    end
endmodule
